/* File: src/swh_regs.vh */
`ifndef SWH_REGS_VH
`define SWH_REGS_VH

// ---------------------------------------------------------------
// timing, in ticks of the 25 MHz core clock
// ---------------------------------------------------------------
// 200ms reset stretch
`define SWH_RESET_STRETCH_CYC 26'h4c4b40
// 1.6s watchdog period
`define SWH_WATCHDOG_PERIOD_CYC 26'h2625a00
`define SWH_CNT_W 26

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SWH_RST_RESET_N 1'b0
`define SWH_RST_REG_ON 1'b0
`define SWH_RST_HOLD_N 1'b1
`define SWH_RST_ENABLE 1'b0
`define SWH_RST_RESET_OE_N 1'b0
`define SWH_RST_UNDERVOLTAGE 1'b1
`define SWH_RST_KICK 1'b0

`endif

/* File: src/swh_sync.v */
`default_nettype none

// ---------------------------------------------------------------
// two-stage synchroniser, constant reset value per bit
// ---------------------------------------------------------------
module swh_sync #(
  parameter W = 4,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock, reset, enable
  input wire i_core_clk,
  input wire i_reset,
  input wire i_ce,
  // data
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= RST;
      sync_r <= RST;
    end else if (i_ce) begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;
endmodule // swh_sync

`default_nettype wire

/* File: src/swh_supervisor.v */
`include "swh_regs.vh"
`default_nettype none

module swh_supervisor #(
  parameter [`SWH_CNT_W-1:0] RESET_STRETCH_CYC = `SWH_RESET_STRETCH_CYC,
  parameter [`SWH_CNT_W-1:0] WATCHDOG_PERIOD_CYC = `SWH_WATCHDOG_PERIOD_CYC
) (
  // clock, reset, enable
  input wire i_core_clk,
  input wire i_reset,
  input wire i_ce,
  // supervisor inputs
  input wire i_undervoltage,
  input wire i_watchdog_kick_in,
  // regulator control inputs; pulls are resolved at the pad
  input wire i_enable,
  input wire i_hold_n,
  // outputs
  output reg o_reset_n,
  output reg o_reset_n_oe_n,
  output reg o_regulator_on
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  wire [3:0] sync_q;
  wire uv_s;
  wire kick_s;
  wire en_s;
  wire hold_n_s;

  // hold resets high, enable low: matches the pad pulls
  // undervoltage resets asserted, so no stretch starts before a real sample
  swh_sync #(
    .W(4),
    .RST({`SWH_RST_UNDERVOLTAGE, `SWH_RST_KICK, `SWH_RST_ENABLE, `SWH_RST_HOLD_N})
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_d({i_undervoltage, i_watchdog_kick_in, i_enable, i_hold_n}),
    .o_q(sync_q)
  );

  assign uv_s = sync_q[3];
  assign kick_s = sync_q[2];
  assign en_s = sync_q[1];
  assign hold_n_s = sync_q[0];

  // ---------------------------------------------------------------
  // kick edge detection
  // ---------------------------------------------------------------
  reg kick_d_r;
  reg kick_valid_r;
  wire kick_edge;

  // a held kick level never clears the counter, only edges do
  // first sample after reset is not an edge
  assign kick_edge = kick_valid_r && (kick_s != kick_d_r);

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      kick_d_r <= `SWH_RST_KICK;
      kick_valid_r <= 1'b0;
    end else if (i_ce) begin
      kick_d_r <= kick_s;
      kick_valid_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // reset supervisor state machine
  // ---------------------------------------------------------------
  localparam [1:0] ST_HOLD = 2'b00;
  localparam [1:0] ST_STRETCH = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`SWH_CNT_W-1:0] stretch_cnt_r;
  reg [`SWH_CNT_W-1:0] stretch_cnt_nxt;
  reg [`SWH_CNT_W-1:0] wd_cnt_r;
  reg [`SWH_CNT_W-1:0] wd_cnt_nxt;
  reg reset_n_nxt;

  function [`SWH_CNT_W-1:0] swh_inc;
    input [`SWH_CNT_W-1:0] v;
    begin
      swh_inc = v + {{(`SWH_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // true on the tick that completes a count of limit ticks
  function swh_at_limit;
    input [`SWH_CNT_W-1:0] v;
    input [`SWH_CNT_W-1:0] limit;
    begin
      swh_at_limit = (swh_inc(v) >= limit);
    end
  endfunction

  always @* begin
    state_nxt = state_r;
    stretch_cnt_nxt = stretch_cnt_r;
    wd_cnt_nxt = wd_cnt_r;
    case (state_r)
      ST_HOLD: begin
        // low while undervoltage persists
        stretch_cnt_nxt = {`SWH_CNT_W{1'b0}};
        wd_cnt_nxt = {`SWH_CNT_W{1'b0}};
        if (!uv_s) begin
          state_nxt = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        // kick edges ignored here; watchdog frozen at zero
        wd_cnt_nxt = {`SWH_CNT_W{1'b0}};
        if (uv_s) begin
          state_nxt = ST_HOLD;
        end else if (swh_at_limit(stretch_cnt_r, RESET_STRETCH_CYC)) begin
          state_nxt = ST_RUN;
          stretch_cnt_nxt = {`SWH_CNT_W{1'b0}};
        end else begin
          stretch_cnt_nxt = swh_inc(stretch_cnt_r);
        end
      end
      ST_RUN: begin
        stretch_cnt_nxt = {`SWH_CNT_W{1'b0}};
        if (uv_s) begin
          state_nxt = ST_HOLD;
          wd_cnt_nxt = {`SWH_CNT_W{1'b0}};
        end else if (kick_edge) begin
          wd_cnt_nxt = {`SWH_CNT_W{1'b0}};
        end else if (swh_at_limit(wd_cnt_r, WATCHDOG_PERIOD_CYC)) begin
          // no disable path exists for the watchdog
          state_nxt = ST_STRETCH;
          wd_cnt_nxt = {`SWH_CNT_W{1'b0}};
        end else begin
          wd_cnt_nxt = swh_inc(wd_cnt_r);
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        stretch_cnt_nxt = {`SWH_CNT_W{1'b0}};
        wd_cnt_nxt = {`SWH_CNT_W{1'b0}};
      end
    endcase
    reset_n_nxt = (state_nxt == ST_RUN);
  end

  // ---------------------------------------------------------------
  // regulator on/off with hold latch
  // ---------------------------------------------------------------
  reg reg_on_nxt;

  always @* begin
    if (en_s) begin
      reg_on_nxt = 1'b1;
    end else if (!hold_n_s && o_regulator_on) begin
      reg_on_nxt = 1'b1;
    end else begin
      // enable low, and hold released or regulator already off: shutdown
      reg_on_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // supervisor state registers
  // ---------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_HOLD;
      stretch_cnt_r <= {`SWH_CNT_W{1'b0}};
      wd_cnt_r <= {`SWH_CNT_W{1'b0}};
    end else if (i_ce) begin
      state_r <= state_nxt;
      stretch_cnt_r <= stretch_cnt_nxt;
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // reset output, open drain
  // ---------------------------------------------------------------
  // level and enable share one next value, so the pad never drives high
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reset_n <= `SWH_RST_RESET_N;
      o_reset_n_oe_n <= `SWH_RST_RESET_OE_N;
    end else if (i_ce) begin
      o_reset_n <= reset_n_nxt;
      // open drain: drive only while asserting low
      o_reset_n_oe_n <= reset_n_nxt;
    end
  end

  // ---------------------------------------------------------------
  // regulator output
  // ---------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_regulator_on <= `SWH_RST_REG_ON;
    end else if (i_ce) begin
      o_regulator_on <= reg_on_nxt;
    end
  end
endmodule // swh_supervisor

`default_nettype wire

/* File: sim/swh_sup_asserts.sv */
`default_nettype none
module swh_sup_chk #(
  parameter int RC = 20,
  parameter int WC = 50
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_undervoltage,
  input wire logic i_watchdog_kick_in,
  input wire logic i_enable,
  input wire logic i_hold_n,
  input wire logic o_reset_n,
  input wire logic o_reset_n_oe_n,
  input wire logic o_regulator_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // run-length counters
  // ----------
  logic [15:0] lo_cnt_r, hi_cnt_r;
  logic kick_r;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      lo_cnt_r <= '0;
      hi_cnt_r <= '0;
      kick_r <= 1'b0;
    end else if (i_ce) begin
      kick_r <= i_watchdog_kick_in;
      lo_cnt_r <= o_reset_n ? '0 : lo_cnt_r + 16'h1;
      // any raw kick change clears it; sync lag covered by slack below
      hi_cnt_r <= (!o_reset_n || kick_r != i_watchdog_kick_in) ? '0 : hi_cnt_r + 16'h1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  // a frozen clock enable holds all design state, so nothing is judged then
  default disable iff (i_reset || !i_ce);
  chk_oe_level: assert property (o_reset_n_oe_n == o_reset_n)
    else $error("reset enable differs from level");
  chk_uv_holds: assert property (i_undervoltage [*4] |-> !o_reset_n)
    else $error("reset high under undervoltage");
  chk_stretch_min: assert property ($rose(o_reset_n) |-> lo_cnt_r >= RC)
    else $error("reset released early");
  chk_wd_bite: assert property (hi_cnt_r <= WC + 4)
    else $error("watchdog did not bite");
  chk_wd_restart: assert property ($rose(o_reset_n) ##0 !i_undervoltage [*8] |-> o_reset_n)
    else $error("watchdog bit right after release");
  chk_en_on: assert property (i_enable [*4] |-> o_regulator_on)
    else $error("regulator off with enable high");
  chk_shutdown_off: assert property ((!i_enable && i_hold_n) [*4] |-> !o_regulator_on)
    else $error("regulator on in shutdown");
  chk_hold_latch: assert property ((!i_hold_n) [*4] ##0 o_regulator_on |=> o_regulator_on)
    else $error("held regulator dropped");
endmodule // swh_sup_chk
bind swh_supervisor swh_sup_chk #(
  .RC(RESET_STRETCH_CYC),
  .WC(WATCHDOG_PERIOD_CYC)
) u_chk (
  .i_core_clk(i_core_clk),
  .i_reset(i_reset),
  .i_ce(i_ce),
  .i_undervoltage(i_undervoltage),
  .i_watchdog_kick_in(i_watchdog_kick_in),
  .i_enable(i_enable),
  .i_hold_n(i_hold_n),
  .o_reset_n(o_reset_n),
  .o_reset_n_oe_n(o_reset_n_oe_n),
  .o_regulator_on(o_regulator_on)
);
`default_nettype wire

/* File: sim/swh_host_model.sv */
`default_nettype none
module swh_host_model #(
  parameter int GAP = 10
) (
  input wire logic i_core_clk,
  input wire logic i_reset_line,
  input wire logic i_kick_en,
  input wire logic i_rude,
  output var logic o_kick
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r = 0;
  initial o_kick = 1'b0;
  // a host in reset runs no code, so it kicks only when told to misbehave
  always @(posedge i_core_clk) begin
    cnt_r <= (cnt_r >= GAP) ? 0 : cnt_r + 1;
    if (i_kick_en && (i_reset_line || i_rude) && cnt_r == GAP) o_kick <= #1 ~o_kick;
  end
endmodule // swh_host_model
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [25:0] RC = 26'h14;
  localparam logic [25:0] WC = 26'h32;
  logic clk = 0, rst = 1, uv = 1, en = 0, hold_n = 1, kick_en = 1, rude = 0, ce = 1;
  wire logic kick, rst_n, oe_n, reg_on;
  // ----------
  // open-drain reset line with pull-up
  // ----------
  wire logic rst_line = oe_n ? 1'b1 : 1'b0;
  int n_mismatch = 0, check_count = 0, c;
  initial forever #20 clk = ~clk;
  swh_supervisor #(.RESET_STRETCH_CYC(RC), .WATCHDOG_PERIOD_CYC(WC)) DUT (
    .i_core_clk(clk), .i_reset(rst), .i_ce(ce), .i_undervoltage(uv),
    .i_watchdog_kick_in(kick), .i_enable(en), .i_hold_n(hold_n),
    .o_reset_n(rst_n), .o_reset_n_oe_n(oe_n), .o_regulator_on(reg_on));
  swh_host_model #(.GAP(10)) u_host (.i_core_clk(clk), .i_reset_line(rst_line),
    .i_kick_en(kick_en), .i_rude(rude), .o_kick(kick));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_rn(input logic v);
    c = 0;
    while (rst_n !== v && c < 4000) begin
      cyc(1);
      c++;
    end
    // a reset level that never arrives counts as a mismatch
    if (rst_n !== v) begin
      n_mismatch++;
      $display("[ERR] %0t reset level %0b never seen", $time, v);
    end
  endtask
  task automatic t_reg();
    hold_n = 0;
    cyc(5);
    chk(reg_on, 0);
    en = 1;
    cyc(4);
    chk(reg_on, 1);
    en = 0;
    cyc(5);
    chk(reg_on, 1);
    hold_n = 1;
    cyc(4);
    chk(reg_on, 0);
    en = 1;
    cyc(4);
    chk(reg_on, 1);
    en = 0;
    cyc(4);
    chk(reg_on, 0);
  endtask
  // clock enable low freezes the regulator output
  task automatic t_ce();
    en = 1;
    cyc(4);
    chk(reg_on, 1);
    ce = 0;
    en = 0;
    cyc(6);
    chk(reg_on, 1);
    ce = 1;
    cyc(4);
    chk(reg_on, 0);
  endtask
  // 2 sync edges plus 1 decision edge before the stretch starts
  task automatic t_uv();
    cyc(4);
    chk(rst_n, 0);
    chk(rst_line, 0);
    uv = 0;
    wait_rn(1);
    chk(c, RC + 3);
    chk(rst_line, 1);
    cyc(3 * WC);
    chk(rst_n, 1);
  endtask
  // last kick lies 0 to 10 edges back, seen 3 edges after it
  task automatic t_bite();
    kick_en = 0;
    wait_rn(0);
    chk(c >= WC - 7 && c <= WC + 4, 1);
    kick_en = 1;
    rude = 1;
    wait_rn(1);
    chk(c, RC);
    rude = 0;
    cyc(2 * WC);
    chk(rst_n, 1);
  endtask
  task automatic t_train();
    kick_en = 0;
    wait_rn(0);
    repeat (2) begin
      wait_rn(1);
      chk(c, RC);
      wait_rn(0);
      chk(c, WC);
    end
    kick_en = 1;
    wait_rn(1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(6);
    rst = 0;
    t_reg();
    t_ce();
    t_uv();
    t_bite();
    t_train();
    // brownout in mid-run
    uv = 1;
    t_uv();
    summarize();
  end
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule // tb
`default_nettype wire
